// ===== design/homing_pkg.sv
package homing_pkg;
	// ************************************************
	// register map (byte addresses)
	// ************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h04;
	localparam logic [7:0] ADDR_PRESET = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_MPOS = 8'h10;
	localparam logic [7:0] ADDR_EPOS = 8'h14;
	localparam logic [7:0] ADDR_SCALE = 8'h18;
	// control word bits
	localparam int CB_SEEK_CW = 0;
	localparam int CB_SEEK_CCW = 1;
	localparam int CB_ARM = 2;
	localparam int CB_PAUSE = 3;
	localparam int CB_ERR_RST = 4;
	localparam int CB_PRE_MOT = 5;
	localparam int CB_PRE_ENC = 6;
	localparam int CB_MOT_FROM_ENC = 7;
	// configuration bits
	localparam int CFG_W = 5;
	localparam int FB_HOME_EN = 0;
	localparam int FB_ARM_EN = 1;
	localparam int FB_CWL_EN = 2;
	localparam int FB_CCWL_EN = 3;
	localparam int FB_ENC_EN = 4;
	localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
	// status bits
	localparam int SB_BUSY = 0;
	localparam int SB_HOMED = 1;
	localparam int SB_FAULT = 2;
	localparam int SB_REFUSED = 3;
	localparam int SB_STATE = 4;
	// scale: steps per turn low half, encoder counts per turn high half
	localparam logic [31:0] SCALE_RST = 32'h1000_07d0;
	localparam logic signed [31:0] PRESET_MAX = 32'sh007f_ffff;
	// ************************************************
	// timing
	// ************************************************
	localparam int unsigned PAUSE_MS = 2000;
	localparam int unsigned CLK_KHZ = 250000;
	localparam int unsigned PAUSE_CYCLES = PAUSE_MS * CLK_KHZ;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_APPROACH = 9'h002,
		ST_DECEL1 = 9'h004,
		ST_PAUSE1 = 9'h008,
		ST_REVERSE = 9'h010,
		ST_DECEL2 = 9'h020,
		ST_PAUSE2 = 9'h040,
		ST_RETURN = 9'h080,
		ST_ABORT = 9'h100
	} seek_state_t;

	typedef struct packed {
		logic run;
		logic cw;
		logic fast;
		logic halt;
	} motion_t;

	typedef struct packed {
		seek_state_t st;
		motion_t mo;
		logic dir_cw;
		logic armed;
		logic arm_lvl;
		logic pause_lvl;
		logic fault;
		logic refused;
		logic homed;
		logic done;
		logic [31:0] timer;
		logic [CFG_W-1:0] cfg;
		logic [31:0] preset;
		logic [31:0] scale;
		logic signed [31:0] mpos;
		logic signed [31:0] epos;
		logic [31:0] rdata;
		logic [2:0] s1;
		logic [2:0] s2;
		logic home_d;
	} core_t;
endpackage : homing_pkg

// ===== design/stepper_homing_sequencer.sv
// Functional notes
// [RL1] Seek-home completion at home clears the motor position counter.
// [RL2] Completion also clears encoder position when encoder present and enabled.
// [RL3] Without defined home only absolute moves are disallowed; homed status shown.
// [RL4] Motor and encoder presets accepted only within plus/minus 8,388,607.
// [RL5] Presets: motor alone, encoder alone, motor from encoder.
// [RL6] Motor-from-encoder scales by steps per turn over counts per turn.
// [RL7] Clockwise seek starts clockwise, ends on home at starting speed; ccw mirrors.
// [RL8] Seek refused unless an input is configured as home sensor.
// [RL9] With arming, home ignored until arm bit rises, then next home edge.
// [RL10] Arming off after defaults; armed without arm bit never homes (code still homes via a travel-limit reverse and return).
// [RL11] No limits configured means no overtravel handling while homing.
// [RL12] Accelerate, run to home, decelerate, stop, wait two seconds.
// [RL13] Reverse fast until home inactive, decelerate, stop, wait two seconds.
// [RL14] Final return at starting speed, stop on home rising edge.
// [RL15] Home active at command start skips to reverse run.
// [RL16] Armed: arm rise starts decel; stop as soon as home active.
// [RL17] Armed approach never drops below starting speed.
// [RL18] Hunt starts on arm rise alone; dropping bit later does not cancel.
// [RL19] Travel-direction limit: immediate stop, pause, reverse, pause, return.
// [RL20] Opposite limit stops motion and reports seek fault.
// [RL21] Travel limit active at command start begins at reverse acceleration.
// [RL22] Counter-clockwise seek mirrors clockwise in every direction.
// [RL23] Pause bit toggle aborts seek by decel and stop; no resume.
// [RL24] Pauses timed from clock counter; fault held until error reset.
`timescale 1ns/100ps
`default_nettype none
module stepper_homing_sequencer #(
	parameter int unsigned PAUSE_CYC = homing_pkg::PAUSE_CYCLES
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic home_i,
	input wire logic cw_limit_i,
	input wire logic ccw_limit_i,
	input wire logic at_start_speed_i,
	input wire logic motor_step_i,
	input wire logic enc_up_i,
	input wire logic enc_down_i,
	output homing_pkg::motion_t motion_o,
	output logic homed_o,
	output logic seek_fault_o,
	output logic seek_done_o
);
	// ************************************************
	// helpers
	// ************************************************
	function automatic logic in_range(input logic [31:0] v);
		in_range = ($signed(v) <= homing_pkg::PRESET_MAX) && ($signed(v) >= -homing_pkg::PRESET_MAX);
	endfunction : in_range

	function automatic logic [31:0] pos_step(input logic [31:0] p, input logic up, input logic dn);
		pos_step = p + {31'h0000_0000, up} - {31'h0000_0000, dn};
	endfunction : pos_step

	homing_pkg::core_t r_reg;
	homing_pkg::core_t r_next;

	logic ctrl_wr;
	logic home_lvl;
	logic home_rise;
	logic lim_cw;
	logic lim_ccw;
	logic fwd_lim;
	logic opp_lim;
	logic arm_rise;
	logic pause_tog;
	logic busy;
	logic new_cw;
	logic signed [63:0] scaled;

	always_comb begin
		ctrl_wr = wr_i && (addr_i == homing_pkg::ADDR_CTRL);
		home_lvl = r_reg.s2[0] && r_reg.cfg[homing_pkg::FB_HOME_EN];
		home_rise = home_lvl && !r_reg.home_d;
		// limits only count when configured [RL11]
		lim_cw = r_reg.s2[1] && r_reg.cfg[homing_pkg::FB_CWL_EN];
		lim_ccw = r_reg.s2[2] && r_reg.cfg[homing_pkg::FB_CCWL_EN];
		// limits judged against the seek direction [RL22]
		fwd_lim = r_reg.dir_cw ? lim_cw : lim_ccw;
		opp_lim = r_reg.dir_cw ? lim_ccw : lim_cw;
		// only the write edge counts, never the level [RL18]
		arm_rise = ctrl_wr && wdata_i[homing_pkg::CB_ARM] && !r_reg.arm_lvl;
		pause_tog = ctrl_wr && (wdata_i[homing_pkg::CB_PAUSE] != r_reg.pause_lvl);
		busy = (r_reg.st != homing_pkg::ST_IDLE);
		new_cw = wdata_i[homing_pkg::CB_SEEK_CW];
		// steps per turn over counts per turn [RL6]
		if (r_reg.scale[31:16] == 16'h0000) begin
			scaled = 64'sh0;
		end else begin
			scaled = ($signed({{32{r_reg.epos[31]}}, r_reg.epos}) * $signed({48'h0, r_reg.scale[15:0]}))
				/ $signed({48'h0, r_reg.scale[31:16]});
		end
	end

	// ************************************************
	// next state
	// ************************************************
	always_comb begin
		r_next = r_reg;
		r_next.mo.halt = 1'b0;
		r_next.done = 1'b0;
		r_next.s1 = {ccw_limit_i, cw_limit_i, home_i};
		r_next.s2 = r_reg.s1;
		r_next.home_d = home_lvl;
		r_next.mpos = pos_step(r_reg.mpos, motor_step_i & r_reg.mo.cw, motor_step_i & ~r_reg.mo.cw);
		r_next.epos = pos_step(r_reg.epos, enc_up_i, enc_down_i);
		// register writes; clears come first so a same-cycle set wins [RL24]
		if (ctrl_wr) begin
			r_next.arm_lvl = wdata_i[homing_pkg::CB_ARM];
			r_next.pause_lvl = wdata_i[homing_pkg::CB_PAUSE];
			if (wdata_i[homing_pkg::CB_ERR_RST]) begin
				r_next.fault = 1'b0;
				r_next.refused = 1'b0;
			end
			if (wdata_i[homing_pkg::CB_PRE_MOT]) begin
				if (in_range(r_reg.preset)) begin
					r_next.mpos = r_reg.preset; // [RL5]
				end else begin
					r_next.refused = 1'b1; // [RL4]
				end
			end
			if (wdata_i[homing_pkg::CB_PRE_ENC]) begin
				if (in_range(r_reg.preset)) begin
					r_next.epos = r_reg.preset; // [RL5]
				end else begin
					r_next.refused = 1'b1; // [RL4]
				end
			end
			if (wdata_i[homing_pkg::CB_MOT_FROM_ENC]) begin
				r_next.mpos = scaled[31:0]; // [RL5] [RL6]
			end
		end
		if (wr_i && addr_i == homing_pkg::ADDR_CFG) begin
			r_next.cfg = wdata_i[homing_pkg::CFG_W-1:0];
		end
		if (wr_i && addr_i == homing_pkg::ADDR_PRESET) begin
			r_next.preset = wdata_i;
		end
		if (wr_i && addr_i == homing_pkg::ADDR_SCALE) begin
			r_next.scale = wdata_i;
		end
		// ************************************************
		// seek sequencer
		// ************************************************
		if (busy && opp_lim) begin
			r_next.mo.run = 1'b0; // [RL20]
			r_next.mo.halt = 1'b1;
			r_next.fault = 1'b1;
			r_next.st = homing_pkg::ST_IDLE;
		end else if (busy && pause_tog && r_reg.st != homing_pkg::ST_ABORT) begin
			r_next.mo.fast = 1'b0; // [RL23]
			r_next.st = homing_pkg::ST_ABORT;
		end else begin
			case (r_reg.st)
				homing_pkg::ST_IDLE: begin
					if (ctrl_wr && (new_cw || wdata_i[homing_pkg::CB_SEEK_CCW])) begin
						if (!r_reg.cfg[homing_pkg::FB_HOME_EN]) begin
							r_next.refused = 1'b1; // [RL8]
						end else begin
							r_next.dir_cw = new_cw; // [RL7] [RL22]
							r_next.armed = 1'b0;
							r_next.mo.run = 1'b1;
							r_next.mo.fast = 1'b1;
							if ((new_cw ? lim_cw : lim_ccw) ||
								(home_lvl && !r_reg.cfg[homing_pkg::FB_ARM_EN])) begin
								r_next.mo.cw = ~new_cw; // [RL15] [RL21]
								r_next.st = homing_pkg::ST_REVERSE;
							end else begin
								r_next.mo.cw = new_cw;
								r_next.st = homing_pkg::ST_APPROACH;
							end
						end
					end
				end
				homing_pkg::ST_APPROACH: begin
					if (fwd_lim) begin
						r_next.mo.run = 1'b0; // [RL19]
						r_next.mo.halt = 1'b1;
						r_next.timer = PAUSE_CYC;
						r_next.st = homing_pkg::ST_PAUSE1;
					end else if (r_reg.cfg[homing_pkg::FB_ARM_EN]) begin
						// home ignored until armed [RL9] [RL10]
						if (arm_rise) begin
							r_next.armed = 1'b1; // [RL16] [RL18]
							r_next.mo.fast = 1'b0; // [RL17]
						end
						if (r_reg.armed && home_rise) begin
							r_next.mo.run = 1'b0; // [RL16]
							r_next.mo.halt = 1'b1;
							r_next.done = 1'b1;
							r_next.homed = 1'b1;
							r_next.mpos = 32'h0000_0000; // [RL1]
							if (r_reg.cfg[homing_pkg::FB_ENC_EN]) begin
								r_next.epos = 32'h0000_0000; // [RL2]
							end
							r_next.st = homing_pkg::ST_IDLE;
						end
					end else if (home_lvl) begin
						r_next.mo.fast = 1'b0; // [RL12]
						r_next.st = homing_pkg::ST_DECEL1;
					end
				end
				homing_pkg::ST_DECEL1, homing_pkg::ST_DECEL2: begin
					if (at_start_speed_i) begin
						r_next.mo.run = 1'b0; // [RL12] [RL13]
						r_next.timer = PAUSE_CYC;
						r_next.st = (r_reg.st == homing_pkg::ST_DECEL1) ?
							homing_pkg::ST_PAUSE1 : homing_pkg::ST_PAUSE2;
					end
				end
				homing_pkg::ST_PAUSE1: begin
					r_next.timer = r_reg.timer - 32'h0000_0001; // [RL24]
					if (r_reg.timer <= 32'h0000_0001) begin
						r_next.mo.run = 1'b1; // [RL13]
						r_next.mo.fast = 1'b1;
						r_next.mo.cw = ~r_reg.dir_cw;
						r_next.st = homing_pkg::ST_REVERSE;
					end
				end
				homing_pkg::ST_REVERSE: begin
					if (!home_lvl) begin
						r_next.mo.fast = 1'b0; // [RL13]
						r_next.st = homing_pkg::ST_DECEL2;
					end
				end
				homing_pkg::ST_PAUSE2: begin
					r_next.timer = r_reg.timer - 32'h0000_0001; // [RL24]
					if (r_reg.timer <= 32'h0000_0001) begin
						r_next.mo.run = 1'b1; // [RL14]
						r_next.mo.fast = 1'b0;
						r_next.mo.cw = r_reg.dir_cw;
						r_next.st = homing_pkg::ST_RETURN;
					end
				end
				homing_pkg::ST_RETURN: begin
					if (home_rise) begin
						r_next.mo.run = 1'b0; // [RL14] [RL7]
						r_next.done = 1'b1;
						r_next.homed = 1'b1;
						r_next.mpos = 32'h0000_0000; // [RL1]
						if (r_reg.cfg[homing_pkg::FB_ENC_EN]) begin
							r_next.epos = 32'h0000_0000; // [RL2]
						end
						r_next.st = homing_pkg::ST_IDLE;
					end
				end
				homing_pkg::ST_ABORT: begin
					if (at_start_speed_i) begin
						r_next.mo.run = 1'b0; // [RL23]
						r_next.st = homing_pkg::ST_IDLE;
					end
				end
				default: begin
					r_next.mo.run = 1'b0;
					r_next.st = homing_pkg::ST_IDLE;
				end
			endcase
		end
		// ************************************************
		// read port
		// ************************************************
		r_next.rdata = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				homing_pkg::ADDR_CFG: r_next.rdata = {27'h0, r_reg.cfg};
				homing_pkg::ADDR_PRESET: r_next.rdata = r_reg.preset;
				homing_pkg::ADDR_SCALE: r_next.rdata = r_reg.scale;
				homing_pkg::ADDR_MPOS: r_next.rdata = r_reg.mpos;
				homing_pkg::ADDR_EPOS: r_next.rdata = r_reg.epos;
				homing_pkg::ADDR_STATUS: r_next.rdata = {19'h0, r_reg.st, r_reg.refused, r_reg.fault,
					r_reg.homed, busy}; // [RL3]
				default: r_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			r_reg <= '0;
			r_reg.st <= homing_pkg::ST_IDLE;
			r_reg.cfg <= homing_pkg::CFG_RST; // [RL10]
			r_reg.scale <= homing_pkg::SCALE_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign rdata_o = r_reg.rdata;
	assign motion_o = r_reg.mo;
	assign homed_o = r_reg.homed;
	assign seek_fault_o = r_reg.fault;
	assign seek_done_o = r_reg.done;

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	sequence s_pause_end;
		r_reg.st == homing_pkg::ST_PAUSE1 && r_reg.timer == 32'h0000_0001 && !opp_lim && !pause_tog;
	endsequence
	sequence s_reverse_fast;
		r_reg.st == homing_pkg::ST_REVERSE && r_reg.mo.run && r_reg.mo.fast && r_reg.mo.cw != r_reg.dir_cw;
	endsequence

	AST_HOME_ZERO: assert property (r_reg.st == homing_pkg::ST_RETURN && home_rise && !opp_lim && !pause_tog
		|=> r_reg.mpos == 0 && r_reg.done && r_reg.st == homing_pkg::ST_IDLE) else $error("motor pos not zeroed"); // [RL1]
	AST_ENC_ZERO: assert property (r_reg.done && r_reg.cfg[homing_pkg::FB_ENC_EN] && !$past(enc_up_i)
		|-> r_reg.epos == 0) else $error("encoder pos not zeroed"); // [RL2]
	AST_REFUSE: assert property (!busy && ctrl_wr && wdata_i[homing_pkg::CB_SEEK_CW] && !r_reg.cfg[homing_pkg::FB_HOME_EN]
		|=> !busy && r_reg.refused && !r_reg.mo.run) else $error("seek not refused"); // [RL8]
	AST_PRESET_RANGE: assert property (ctrl_wr && wdata_i[homing_pkg::CB_PRE_MOT] && !in_range(r_reg.preset)
		|=> r_reg.refused) else $error("bad preset taken"); // [RL4]
	AST_PAUSE_END: assert property (s_pause_end |=> s_reverse_fast) else $error("reverse run missing"); // [RL13]
	AST_OPP_LIMIT: assert property (busy && opp_lim |=> r_reg.fault && !r_reg.mo.run && !busy ##1 r_reg.fault)
		else $error("opposite limit not faulted"); // [RL20]
	AST_FWD_LIMIT: assert property (r_reg.st == homing_pkg::ST_APPROACH && fwd_lim && !opp_lim && !pause_tog
		|=> r_reg.st == homing_pkg::ST_PAUSE1 && !r_reg.mo.run && r_reg.mo.halt) else $error("limit stop missing"); // [RL19]
	AST_ARM_IGNORE: assert property (r_reg.st == homing_pkg::ST_APPROACH && r_reg.cfg[homing_pkg::FB_ARM_EN] && !r_reg.armed
		&& !fwd_lim && !opp_lim && !pause_tog |=> r_reg.st == homing_pkg::ST_APPROACH) else $error("home not ignored"); // [RL9]
	AST_RETURN_SLOW: assert property (r_reg.st == homing_pkg::ST_RETURN |-> r_reg.mo.run && !r_reg.mo.fast
		&& r_reg.mo.cw == r_reg.dir_cw) else $error("return not slow toward home"); // [RL14]
	AST_ABORT: assert property (busy && pause_tog && !opp_lim && r_reg.st != homing_pkg::ST_ABORT
		|=> r_reg.st == homing_pkg::ST_ABORT && !r_reg.mo.fast) else $error("abort missing"); // [RL23]

	sequence s_abort_slow;
		r_reg.st == homing_pkg::ST_ABORT && at_start_speed_i && !opp_lim;
	endsequence

	AST_ABORT_STOP: assert property (s_abort_slow
		|=> !r_reg.mo.run && r_reg.st == homing_pkg::ST_IDLE) else $error("aborted seek not stopped"); // [RL23]
	AST_START_REVERSE: assert property (!busy && ctrl_wr && wdata_i[homing_pkg::CB_SEEK_CW]
		&& r_reg.cfg[homing_pkg::FB_HOME_EN] && lim_cw
		|=> r_reg.st == homing_pkg::ST_REVERSE && !r_reg.mo.cw && r_reg.mo.fast) else $error("no reverse start"); // [RL21]
	AST_ARM_DECEL: assert property (r_reg.st == homing_pkg::ST_APPROACH && r_reg.cfg[homing_pkg::FB_ARM_EN]
		&& arm_rise && !fwd_lim && !opp_lim && !pause_tog
		|=> r_reg.armed && !r_reg.mo.fast) else $error("arm rise did not slow"); // [RL16]
	AST_FAULT_HOLD: assert property (r_reg.fault && !(ctrl_wr && wdata_i[homing_pkg::CB_ERR_RST])
		|=> r_reg.fault) else $error("fault dropped without reset"); // [RL24]
	AST_DECEL_PAUSE: assert property (r_reg.st == homing_pkg::ST_DECEL1 && at_start_speed_i && !opp_lim && !pause_tog
		|=> !r_reg.mo.run && r_reg.st == homing_pkg::ST_PAUSE1 && r_reg.timer == PAUSE_CYC)
		else $error("stop before pause missing"); // [RL12]
	AST_REVERSE_END: assert property (r_reg.st == homing_pkg::ST_REVERSE && !home_lvl && !opp_lim && !pause_tog
		|=> r_reg.st == homing_pkg::ST_DECEL2 && !r_reg.mo.fast) else $error("reverse run not ended"); // [RL13]
endmodule : stepper_homing_sequencer
`default_nettype wire

// ===== tb/axis_model.sv
`timescale 1ns/100ps
`default_nettype none
module axis_model (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire homing_pkg::motion_t motion_i,
	input wire logic pos_load_i,
	input wire logic signed [15:0] pos_val_i,
	output logic home_o,
	output logic at_start_o,
	output logic step_o,
	output logic enc_up_o,
	output logic enc_down_o
);
	// ************************************************
	// axis position, steps and speed feedback
	// ************************************************
	logic signed [15:0] pos;
	logic [1:0] ph;
	logic [1:0] slow;
	always @(posedge mclk_i) begin
		step_o <= 1'b0;
		enc_up_o <= 1'b0;
		enc_down_o <= 1'b0;
		if (rst_i) begin
			ph <= 2'h0;
			slow <= 2'h0;
			pos <= 16'sh0;
		end else begin
			// ramp down takes three cycles to reach starting speed
			slow <= motion_i.fast ? 2'h0 : (slow == 2'h3 ? slow : slow + 2'h1);
			if (motion_i.run) begin
				ph <= ph + 2'h1;
				if (ph == 2'h3) begin
					step_o <= 1'b1;
					enc_up_o <= motion_i.cw;
					enc_down_o <= !motion_i.cw;
					pos <= motion_i.cw ? pos + 16'sh1 : pos - 16'sh1;
				end
			end
			if (pos_load_i) begin
				pos <= pos_val_i;
			end
		end
	end
	assign at_start_o = (slow == 2'h3);
	// home flag repeats every 64 steps
	assign home_o = (pos[5:0] >= 6'h28) && (pos[5:0] < 6'h3c);
endmodule : axis_model
`default_nettype wire

// ===== tb/stepper_homing_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module stepper_homing_sequencer_tb;
	localparam int PC = 20;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic cw_lim = 1'b0;
	logic ccw_lim = 1'b0;
	logic pos_ld = 1'b0;
	logic signed [15:0] pos_v = 16'sh0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] st;
	homing_pkg::motion_t motion;
	logic home, at_start, step, eu, ed, homed, fault, done;
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0;
	always #2 mclk = ~mclk;
	stepper_homing_sequencer #(.PAUSE_CYC(PC)) i_stepper_homing_sequencer (.mclk_i(mclk), .rst_i(rst),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .home_i(home),
		.cw_limit_i(cw_lim), .ccw_limit_i(ccw_lim), .at_start_speed_i(at_start), .motor_step_i(step),
		.enc_up_i(eu), .enc_down_i(ed), .motion_o(motion), .homed_o(homed), .seek_fault_o(fault),
		.seek_done_o(done));
	axis_model i_axis_model (.mclk_i(mclk), .rst_i(rst), .motion_i(motion), .pos_load_i(pos_ld),
		.pos_val_i(pos_v), .home_o(home),
		.at_start_o(at_start), .step_o(step), .enc_up_o(eu), .enc_down_o(ed));
	// ************************************************
	// bus and check tasks
	// ************************************************
	task tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge mclk);
		wr_s <= 1'b0;
	endtask : wr
	task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge mclk);
		rd_s <= 1'b0;
		@(negedge mclk);
		st = rdata;
		chk(n, e, st);
	endtask : rchk
	task nwait(input int n);
		repeat (n) @(negedge mclk);
	endtask : nwait
	task start(input logic [31:0] cfg, input logic [15:0] p, input logic cl, input logic cc, input logic [31:0] c);
		@(posedge mclk);
		cw_lim <= cl;
		ccw_lim <= cc;
		pos_v <= p;
		pos_ld <= 1'b1;
		wr(homing_pkg::ADDR_CFG, cfg);
		pos_ld <= 1'b0;
		nwait(4);
		wr(homing_pkg::ADDR_CTRL, c);
	endtask : start
	// waits for the next motion phase; optionally measures the stop before it
	task wait_run(input logic cw, input logic fast, input logic pz);
		int n;
		n = 0;
		@(negedge mclk);
		while (pz && motion.run === 1'b1 && n < 4000) begin
			@(negedge mclk);
			n++;
		end
		n = 0;
		while (motion.run !== 1'b1 && n < 4000) begin
			@(negedge mclk);
			n++;
		end
		chk("dir", cw, motion.cw);
		chk("fast", fast, motion.fast);
		if (pz) chk("pause", 1, n >= PC - 1 && n <= PC + 3);
	endtask : wait_run
	task wait_done;
		int n;
		n = 0;
		while (done !== 1'b1 && n < 4000) begin
			@(negedge mclk);
			n++;
		end
		chk("done", 1, done);
	endtask : wait_done
	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		rchk("status", homing_pkg::ADDR_STATUS, 32'h10);
		rchk("scale", homing_pkg::ADDR_SCALE, 32'h1000_07d0);
		rchk("unmapped", 8'hfc, 32'h0);
		chk("homed", 0, homed);
		wr(homing_pkg::ADDR_CTRL, 32'h1);
		rchk("refused", homing_pkg::ADDR_STATUS, 32'h18);
		chk("run", 0, motion.run);
		wr(homing_pkg::ADDR_CTRL, 32'h10);
		rchk("status", homing_pkg::ADDR_STATUS, 32'h10);
		wr(homing_pkg::ADDR_PRESET, 32'h007f_ffff);
		wr(homing_pkg::ADDR_CTRL, 32'h20);
		rchk("mpos", homing_pkg::ADDR_MPOS, 32'h007f_ffff);
		wr(homing_pkg::ADDR_PRESET, 32'h0080_0000);
		wr(homing_pkg::ADDR_CTRL, 32'h20);
		rchk("mpos", homing_pkg::ADDR_MPOS, 32'h007f_ffff);
		rchk("refused", homing_pkg::ADDR_STATUS, 32'h18);
		wr(homing_pkg::ADDR_CTRL, 32'h10);
		wr(homing_pkg::ADDR_PRESET, 32'hff80_0001);
		wr(homing_pkg::ADDR_CTRL, 32'h40);
		rchk("epos", homing_pkg::ADDR_EPOS, 32'hff80_0001);
		wr(homing_pkg::ADDR_PRESET, 32'h1000);
		wr(homing_pkg::ADDR_CTRL, 32'h40);
		wr(homing_pkg::ADDR_CTRL, 32'h80);
		rchk("mpos", homing_pkg::ADDR_MPOS, 32'h7d0);
		// limits asserted but not configured
		start(32'h11, 16'h0, 1'b1, 1'b1, 32'h1);
		wait_run(1'b1, 1'b1, 1'b0);
		wait_run(1'b0, 1'b1, 1'b1);
		wait_run(1'b1, 1'b0, 1'b1);
		wait_done();
		rchk("mpos", homing_pkg::ADDR_MPOS, 32'h0);
		rchk("epos", homing_pkg::ADDR_EPOS, 32'h0);
		chk("homed", 1, homed);
		start(32'h01, 16'h32, 1'b0, 1'b0, 32'h2);
		wait_run(1'b1, 1'b1, 1'b0);
		wait_run(1'b0, 1'b0, 1'b1);
		wait_done();
		start(32'h05, 16'h0, 1'b1, 1'b0, 32'h1);
		wait_run(1'b0, 1'b1, 1'b0);
		@(posedge mclk);
		cw_lim <= 1'b0;
		wait_run(1'b1, 1'b0, 1'b1);
		wait_done();
		start(32'h05, 16'h0, 1'b0, 1'b0, 32'h1);
		wait_run(1'b1, 1'b1, 1'b0);
		@(posedge mclk);
		cw_lim <= 1'b1;
		wait_run(1'b0, 1'b1, 1'b1);
		@(posedge mclk);
		cw_lim <= 1'b0;
		wait_run(1'b1, 1'b0, 1'b1);
		wait_done();
		start(32'h0d, 16'h0, 1'b0, 1'b0, 32'h1);
		wait_run(1'b1, 1'b1, 1'b0);
		@(posedge mclk);
		ccw_lim <= 1'b1;
		nwait(6);
		chk("fault", 1, fault);
		chk("run", 0, motion.run);
		@(posedge mclk);
		ccw_lim <= 1'b0;
		nwait(4);
		chk("fault", 1, fault);
		wr(homing_pkg::ADDR_CTRL, 32'h10);
		nwait(2);
		chk("fault", 0, fault);
		start(32'h03, 16'h0, 1'b0, 1'b0, 32'h1);
		wait_run(1'b1, 1'b1, 1'b0);
		nwait(280);
		chk("fast", 1, motion.fast);
		wr(homing_pkg::ADDR_CTRL, 32'h4);
		nwait(3);
		chk("fast", 0, motion.fast);
		wr(homing_pkg::ADDR_CTRL, 32'h0);
		nwait(12);
		chk("run", 1, motion.run);
		wait_done();
		rchk("mpos", homing_pkg::ADDR_MPOS, 32'h0);
		start(32'h01, 16'h0, 1'b0, 1'b0, 32'h1);
		wait_run(1'b1, 1'b1, 1'b0);
		wr(homing_pkg::ADDR_CTRL, 32'h8);
		nwait(2);
		chk("fast", 0, motion.fast);
		nwait(10);
		chk("run", 0, motion.run);
		rchk("status", homing_pkg::ADDR_STATUS, 32'h12);
		wr(homing_pkg::ADDR_CTRL, 32'h0);
		nwait(3);
		chk("run", 0, motion.run);
		tally_and_finish();
	end
endmodule : stepper_homing_sequencer_tb
`default_nettype wire
